/* psm_status_irq.sv */
// status registers, interrupt masks and their flags behind the serial register port
`include "psm_regs.svh"
module psm_status_irq (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_power_good_output,
  input  wire logic             i_sync_clock_invalid,
  input  wire logic             i_sync_clock_present,
  input  wire logic             i_thermal_shutdown,
  input  wire logic             i_thermal_warning,
  input  wire logic             i_input_overvoltage,
  input  wire logic             i_reg_b_enabled,
  input  wire logic             i_reg_a_enabled,
  input  wire logic             i_reg_b_output_invalid,
  input  wire logic             i_reg_a_output_invalid,
  input  wire logic             i_reg_b_current_limit,
  input  wire logic             i_reg_a_current_limit,
  input  wire logic             i_measurement_done,
  input  wire logic             i_register_reset_event,
  input  wire psm_pkg::psm_byte_t i_otp_mask_1,
  input  wire logic             i_otp_reset_mask,
  input  wire logic             i_wr_en,
  input  wire logic             i_rd_en,
  input  wire psm_pkg::psm_addr_t i_addr,
  input  wire psm_pkg::psm_byte_t i_wdata,
  output psm_pkg::psm_byte_t    o_rdata,
  output logic                  o_power_good_irq_req,
  output logic                  o_sync_clock_irq_req,
  output logic                  o_thermal_warning_irq_req,
  output logic                  o_measurement_ready_irq_req,
  output logic                  o_register_reset_irq_req,
  output logic                  o_irq_flag_top,
  output logic                  o_irq_flag_reg
);
  import psm_pkg::*;

  psm_byte_t mask1_reg, mask1_next;
  logic      rstmask_reg, rstmask_next;
  logic      otp_load_reg, otp_load_next;
  psm_byte_t flag_top_reg, flag_top_next;
  psm_byte_t flag_reg_reg, flag_reg_next;
  psm_byte_t rdata_reg, rdata_next;
  psm_byte_t top_stat, reg_stat;
  logic      clk_change, b_pg_change, a_pg_change;

  // live status words, reserved bits forced to zero
  always_comb begin
    top_stat = `PSM_RESET_ZERO;
    top_stat[`PSM_BIT_PG]    = i_power_good_output;
    top_stat[`PSM_BIT_CLK]   = i_sync_clock_invalid;
    top_stat[`PSM_BIT_TSD]   = i_thermal_shutdown;
    top_stat[`PSM_BIT_TWARN] = i_thermal_warning;
    top_stat[`PSM_BIT_OVP]   = i_input_overvoltage;
    reg_stat = `PSM_RESET_ZERO;
    reg_stat[`PSM_BIT_B_EN]   = i_reg_b_enabled;
    reg_stat[`PSM_BIT_A_EN]   = i_reg_a_enabled;
    reg_stat[`PSM_BIT_B_INV]  = i_reg_b_output_invalid;
    reg_stat[`PSM_BIT_A_INV]  = i_reg_a_output_invalid;
    reg_stat[`PSM_BIT_B_ILIM] = i_reg_b_current_limit;
    reg_stat[`PSM_BIT_A_ILIM] = i_reg_a_current_limit;
  end

  // change detectors for the events that latch flags
  psm_edge u_clk_edge (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (i_sync_clock_present),
    .o_change (clk_change)
  );
  psm_edge u_b_pg_edge (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (i_reg_b_output_invalid),
    .o_change (b_pg_change)
  );
  psm_edge u_a_pg_edge (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_level  (i_reg_a_output_invalid),
    .o_change (a_pg_change)
  );

  // masked requests; held low until the masks are loaded so reset-time zeros leak nothing
  assign o_power_good_irq_req        = ~otp_load_reg & i_power_good_output & ~mask1_reg[`PSM_BIT_PG];
  assign o_sync_clock_irq_req        = ~otp_load_reg & clk_change & ~mask1_reg[`PSM_BIT_CLK];
  assign o_thermal_warning_irq_req   = ~otp_load_reg & i_thermal_warning & ~mask1_reg[`PSM_BIT_TWARN];
  assign o_measurement_ready_irq_req = ~otp_load_reg & i_measurement_done & ~mask1_reg[`PSM_BIT_MEAS];
  assign o_register_reset_irq_req    = ~otp_load_reg & i_register_reset_event & ~rstmask_reg;
  assign o_irq_flag_top              = |flag_top_reg;
  assign o_irq_flag_reg              = |flag_reg_reg;

  // next values: masks, flags and read data
  always_comb begin
    mask1_next    = mask1_reg;
    rstmask_next  = rstmask_reg;
    flag_top_next = flag_top_reg;
    flag_reg_next = flag_reg_reg;
    rdata_next    = rdata_reg;
    otp_load_next = 1'b0; // one-time load lasts a single edge
    if (otp_load_reg) begin
      mask1_next   = i_otp_mask_1 & `PSM_MASK1_RW;
      rstmask_next = i_otp_reset_mask;
    end else if (i_wr_en && i_addr == `PSM_OFF_MASK_1) begin
      mask1_next = i_wdata & `PSM_MASK1_RW;
    end else if (i_wr_en && i_addr == `PSM_OFF_MASK_2) begin
      rstmask_next = i_wdata[`PSM_BIT_RSTREG]; // held only until the next reset reload
    end
    // write-one clears first, then events, so a same-cycle event wins
    if (i_wr_en && i_addr == `PSM_OFF_FLAG_TOP) begin
      flag_top_next = flag_top_next & ~(i_wdata & `PSM_FLAGTOP_RW);
    end
    if (i_wr_en && i_addr == `PSM_OFF_FLAG_REG) begin
      flag_reg_next = flag_reg_next & ~(i_wdata & `PSM_FLAGREG_RW);
    end
    if (clk_change) begin
      flag_top_next[`PSM_BIT_CLK] = 1'b1;
    end
    if (b_pg_change) begin
      flag_reg_next[`PSM_BIT_B_PGF] = 1'b1;
    end
    if (a_pg_change) begin
      flag_reg_next[`PSM_BIT_A_PGF] = 1'b1;
    end
    if (i_rd_en) begin
      unique case (i_addr)
        `PSM_OFF_TOP_STAT: rdata_next = top_stat;
        `PSM_OFF_REG_STAT: rdata_next = reg_stat;
        `PSM_OFF_MASK_1:   rdata_next = mask1_reg;
        `PSM_OFF_MASK_2:   rdata_next = {7'h00, rstmask_reg};
        `PSM_OFF_FLAG_TOP: rdata_next = flag_top_reg;
        `PSM_OFF_FLAG_REG: rdata_next = flag_reg_reg;
        default:           rdata_next = `PSM_RESET_ZERO; // unmapped reads zero
      endcase
    end
  end

  // registers; masks take one-time values on the first edge after release
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask1_reg    <= `PSM_RESET_ZERO;
      rstmask_reg  <= 1'b0;
      otp_load_reg <= 1'b1;
      flag_top_reg <= `PSM_RESET_ZERO;
      flag_reg_reg <= `PSM_RESET_ZERO;
      rdata_reg    <= `PSM_RESET_ZERO;
    end else begin
      mask1_reg    <= mask1_next;
      rstmask_reg  <= rstmask_next;
      otp_load_reg <= otp_load_next;
      flag_top_reg <= flag_top_next;
      flag_reg_reg <= flag_reg_next;
      rdata_reg    <= rdata_next;
    end
  end
  assign o_rdata = rdata_reg;

  // checks on the block clock; all rest while reset is low
  property p_pg_live;
    @(posedge i_clk) disable iff (!i_resetn)
    i_rd_en && i_addr == `PSM_OFF_TOP_STAT |=> o_rdata[`PSM_BIT_PG] == $past(i_power_good_output);
  endproperty
  a_pg_live: assert property (p_pg_live) else $error("power-good status bit differs from pin");

  property p_tsd_live;
    @(posedge i_clk) disable iff (!i_resetn)
    i_rd_en && i_addr == `PSM_OFF_TOP_STAT |=> o_rdata[`PSM_BIT_TSD] == $past(i_thermal_shutdown);
  endproperty
  a_tsd_live: assert property (p_tsd_live) else $error("thermal shutdown status bit differs");

  property p_regstat;
    @(posedge i_clk) disable iff (!i_resetn)
    i_rd_en && i_addr == `PSM_OFF_REG_STAT |=> o_rdata[`PSM_BIT_B_EN] == $past(i_reg_b_enabled)
      && o_rdata[`PSM_BIT_A_INV] == $past(i_reg_a_output_invalid);
  endproperty
  a_regstat: assert property (p_regstat) else $error("regulator status bits differ");

  property p_mask_pg;
    @(posedge i_clk) disable iff (!i_resetn)
    mask1_reg[`PSM_BIT_PG] |-> !o_power_good_irq_req;
  endproperty
  a_mask_pg: assert property (p_mask_pg) else $error("masked power-good request raised");

  property p_clk_mask;
    @(posedge i_clk) disable iff (!i_resetn)
    mask1_reg[`PSM_BIT_CLK] |-> !o_sync_clock_irq_req;
  endproperty
  a_clk_mask: assert property (p_clk_mask) else $error("masked sync clock request raised");

  property p_clk_flag;
    @(posedge i_clk) disable iff (!i_resetn)
    clk_change |=> flag_top_reg[`PSM_BIT_CLK];
  endproperty
  a_clk_flag: assert property (p_clk_flag) else $error("sync clock flag not latched");

  property p_rst_otp;
    @(posedge i_clk) disable iff (!i_resetn)
    otp_load_reg |=> rstmask_reg == $past(i_otp_reset_mask);
  endproperty
  a_rst_otp: assert property (p_rst_otp) else $error("reset mask not loaded from one-time value");

  // main scenarios worth seeing at least once
  c_clk_flag: cover property (@(posedge i_clk) clk_change);
  c_clear: cover property (@(posedge i_clk) i_wr_en && i_addr == `PSM_OFF_FLAG_REG);
  c_irq: cover property (@(posedge i_clk) o_thermal_warning_irq_req);
  c_masked_clock: cover property (@(posedge i_clk) clk_change && mask1_reg[`PSM_BIT_CLK]);
endmodule : psm_status_irq

/* psm_regs.svh */
// register offsets, field positions and reset values of the status and mask block
`ifndef PSM_REGS_SVH
`define PSM_REGS_SVH
`define PSM_OFF_TOP_STAT   8'h1D
`define PSM_OFF_REG_STAT   8'h1E
`define PSM_OFF_MASK_1     8'h20
`define PSM_OFF_MASK_2     8'h21
`define PSM_OFF_FLAG_TOP   8'h19
`define PSM_OFF_FLAG_REG   8'h1B
`define PSM_BIT_PG         7
`define PSM_BIT_CLK        4
`define PSM_BIT_TSD        3
`define PSM_BIT_TWARN      2
`define PSM_BIT_OVP        1
`define PSM_BIT_MEAS       0
`define PSM_BIT_RSTREG     0
`define PSM_BIT_B_EN       7
`define PSM_BIT_B_INV      6
`define PSM_BIT_B_ILIM     4
`define PSM_BIT_A_EN       3
`define PSM_BIT_A_INV      2
`define PSM_BIT_A_ILIM     0
`define PSM_BIT_B_PGF      6
`define PSM_BIT_A_PGF      2
`define PSM_MASK1_RW       8'h95
`define PSM_MASK2_RW       8'h01
`define PSM_FLAGTOP_RW     8'h15
`define PSM_FLAGREG_RW     8'h44
`define PSM_RESET_ZERO     8'h00
`endif

/* psm_pkg.sv */
// types shared by the status and mask block
package psm_pkg;
  typedef logic [7:0] psm_byte_t;
  typedef logic [7:0] psm_addr_t;
endpackage : psm_pkg

/* psm_edge.sv */
// edge detector raising a one-cycle pulse on any change of a live level
module psm_edge (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_level,
  output logic      o_change
);
  logic prev_reg;
  logic prev_next;
  logic armed_reg;
  logic armed_next;
  // previous sample for comparison; armed once a real sample is held
  always_comb begin
    prev_next  = i_level;
    armed_next = 1'b1;
  end
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      prev_reg  <= prev_next;
      armed_reg <= armed_next;
    end
  end
  // a pin idling high gives no false edge after reset; a change in the first cycle is lost
  assign o_change = armed_reg & (prev_reg ^ i_level);
endmodule : psm_edge

/* psm_host_model.sv */
// host model issuing single-byte register accesses
module psm_host_model (
  input  wire logic               i_clk,
  input  wire psm_pkg::psm_byte_t i_rdata,
  output logic                    o_wr_en,
  output logic                    o_rd_en,
  output psm_pkg::psm_addr_t      o_addr,
  output psm_pkg::psm_byte_t      o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import psm_pkg::*;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // address and data park inverted so stale values never look valid
  task automatic wr(input psm_addr_t a, input psm_byte_t d);
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr
  // read data is registered, so it is taken one half cycle after the edge
  task automatic rd(input psm_addr_t a, output psm_byte_t d);
    @(negedge i_clk);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    d       = i_rdata;
  endtask : rd
endmodule : psm_host_model

/* test_psm_status_irq.sv */
// self-checking bench for the status and mask block
`include "psm_regs.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_psm_status_irq;
  timeunit 1ns;
  timeprecision 1ps;
  import psm_pkg::*;
  logic        clk = 1'b0, resetn = 1'b0, ck_on = 1'b0, meas = 1'b0, rst_ev = 1'b0, otp_rst = 1'b1;
  logic [10:0] lv = 11'h000;
  psm_byte_t   otp1 = 8'h95, rdata, wdata, got, m1;
  psm_addr_t   addr;
  logic        wr_en, rd_en, pg_req, ck_req, tw_req, mr_req, rr_req, f_top, f_reg;
  int          n_mismatch = 0, samples_checked = 0;
  logic [31:0] seed = 32'h8B87;
  always #5 clk = ~clk;
  psm_status_irq u_dut (.i_clk(clk), .i_resetn(resetn), .i_power_good_output(lv[10]),
    .i_sync_clock_invalid(lv[9]), .i_sync_clock_present(ck_on), .i_thermal_shutdown(lv[8]),
    .i_thermal_warning(lv[7]), .i_input_overvoltage(lv[6]), .i_reg_b_enabled(lv[5]),
    .i_reg_a_enabled(lv[4]), .i_reg_b_output_invalid(lv[3]), .i_reg_a_output_invalid(lv[2]),
    .i_reg_b_current_limit(lv[1]), .i_reg_a_current_limit(lv[0]), .i_measurement_done(meas),
    .i_register_reset_event(rst_ev), .i_otp_mask_1(otp1), .i_otp_reset_mask(otp_rst),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_power_good_irq_req(pg_req), .o_sync_clock_irq_req(ck_req), .o_thermal_warning_irq_req(tw_req),
    .o_measurement_ready_irq_req(mr_req), .o_register_reset_irq_req(rr_req),
    .o_irq_flag_top(f_top), .o_irq_flag_reg(f_reg));
  psm_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction : lfsr
  // expected live status images, reserved bits zero
  function automatic psm_byte_t top_exp(input logic [10:0] v);
    return {v[10], 2'b00, v[9:6], 1'b0};
  endfunction : top_exp
  function automatic psm_byte_t reg_exp(input logic [10:0] v);
    return {v[5], v[3], 1'b0, v[1], v[4], v[2], 1'b0, v[0]};
  endfunction : reg_exp
  // two idle edges after release: the first one loads the one-time masks
  task automatic do_reset();
    resetn = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #50us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    u_host.rd(`PSM_OFF_MASK_1, got);
    `CHK(got, otp1 & `PSM_MASK1_RW)
    u_host.rd(`PSM_OFF_MASK_2, got);
    `CHK(got, 8'h01)
    u_host.rd(8'h00, got);
    `CHK(got, `PSM_RESET_ZERO)
    // random live levels and masks; status writes must be ignored
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      lv = seed[10:0];
      m1 = seed[23:16] & `PSM_MASK1_RW;
      meas = seed[24];
      rst_ev = seed[25];
      u_host.wr(`PSM_OFF_MASK_1, m1);
      u_host.wr(`PSM_OFF_MASK_2, {7'h00, seed[26]});
      u_host.wr(`PSM_OFF_TOP_STAT, seed[31:24]);
      u_host.rd(`PSM_OFF_TOP_STAT, got);
      `CHK(got, top_exp(lv))
      u_host.rd(`PSM_OFF_REG_STAT, got);
      `CHK(got, reg_exp(lv))
      u_host.rd(`PSM_OFF_MASK_1, got);
      `CHK(got, m1)
      `CHK({pg_req, tw_req, mr_req, rr_req}, {lv[10] & ~m1[7], lv[7] & ~m1[2], meas & ~m1[0], rst_ev & ~seed[26]})
    end
    // quiet inputs, unmask, then clear every flag
    lv = 11'h000;
    meas = 1'b0;
    rst_ev = 1'b0;
    u_host.wr(`PSM_OFF_MASK_1, 8'h00);
    repeat (3) @(negedge clk);
    u_host.wr(`PSM_OFF_FLAG_TOP, 8'hFF);
    u_host.wr(`PSM_OFF_FLAG_REG, 8'hFF);
    `CHK({f_top, f_reg}, 2'b00)
    // external clock appears, then disappears
    for (int k = 0; k < 2; k++) begin
      u_host.wr(`PSM_OFF_MASK_1, (k == 0) ? 8'h00 : 8'h10);
      ck_on = ~ck_on;
      #1;
      `CHK(ck_req, (k == 0))
      repeat (3) @(negedge clk);
      `CHK(ck_req, 1'b0)
      u_host.rd(`PSM_OFF_FLAG_TOP, got);
      `CHK({got[`PSM_BIT_CLK], f_top}, 2'b11)
      u_host.wr(`PSM_OFF_FLAG_TOP, 8'h10);
      u_host.rd(`PSM_OFF_FLAG_TOP, got);
      `CHK({got[`PSM_BIT_CLK], f_top}, 2'b00)
    end
    // power-good event on regulator a, then b
    for (int k = 0; k < 2; k++) begin
      lv[2 + k] = 1'b1;
      repeat (3) @(negedge clk);
      u_host.rd(`PSM_OFF_FLAG_REG, got);
      `CHK({got[2 + 4 * k], f_reg}, 2'b11)
      u_host.wr(`PSM_OFF_FLAG_REG, 8'h44);
      u_host.rd(`PSM_OFF_FLAG_REG, got);
      `CHK({got[2 + 4 * k], f_reg}, 2'b00)
    end
    // a written reset mask must not survive the next reset
    otp_rst = 1'b0;
    otp1 = 8'h14;
    u_host.wr(`PSM_OFF_MASK_2, 8'h01);
    do_reset();
    `CHK({f_top, f_reg}, 2'b00)
    u_host.rd(`PSM_OFF_MASK_2, got);
    `CHK(got, 8'h00)
    u_host.rd(`PSM_OFF_MASK_1, got);
    `CHK(got, 8'h14)
    tally_and_finish();
  end
endmodule : test_psm_status_irq
